// ---- include/crtc_pkg.sv ----
`default_nettype none
package crtc_pkg;
  // register indices of the control file
  localparam logic [4:0] IDX_HTOTAL = 5'h00;
  localparam logic [4:0] IDX_HDISP = 5'h01;
  localparam logic [4:0] IDX_HSYNC_POS = 5'h02;
  localparam logic [4:0] IDX_SYNC_WIDTH = 5'h03;
  localparam logic [4:0] IDX_VTOTAL = 5'h04;
  localparam logic [4:0] IDX_VADJ = 5'h05;
  localparam logic [4:0] IDX_VDISP = 5'h06;
  localparam logic [4:0] IDX_VSYNC_POS = 5'h07;
  localparam logic [4:0] IDX_MODE = 5'h08;
  localparam logic [4:0] IDX_MAX_ROW = 5'h09;
  localparam logic [4:0] IDX_CUR_START = 5'h0a;
  localparam logic [4:0] IDX_CUR_END = 5'h0b;
  localparam logic [4:0] IDX_START_HI = 5'h0c;
  localparam logic [4:0] IDX_START_LO = 5'h0d;
  localparam logic [4:0] IDX_CUR_HI = 5'h0e;
  localparam logic [4:0] IDX_CUR_LO = 5'h0f;
  localparam logic [4:0] IDX_PEN_HI = 5'h10;
  localparam logic [4:0] IDX_PEN_LO = 5'h11;
  localparam int NUM_CTRL_REGS = 18;
  // field layout
  localparam int HSW_LSB = 0;
  localparam int VSW_LSB = 4;
  localparam int CUR_MODE_LSB = 5;
  localparam int ADDR_W = 14;
  localparam int ROW_W = 5;
  // cursor blink modes (cursor start bits 6:5)
  localparam logic [1:0] CUR_ON = 2'h0;
  localparam logic [1:0] CUR_OFF = 2'h1;
  localparam logic [1:0] CUR_FAST = 2'h2;
  localparam logic [1:0] CUR_SLOW = 2'h3;
  // blink periods in fields
  localparam logic [4:0] BLINK_FAST_FIELDS = 5'h0f;
  localparam logic [4:0] BLINK_SLOW_FIELDS = 5'h1f;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
endpackage
`default_nettype wire

// ---- hw/crtc_host_bus.sv ----
`timescale 1ns/10ps
`default_nettype none
// host strobe interface: index register, write strobes and read mux
module crtc_host_bus (
  input wire logic core_clk_i,
  input wire logic chip_sel_n_i,
  input wire logic register_select_i,
  input wire logic rd_wr_n_i,
  input wire logic enable_i,
  input wire logic [7:0] host_data_lines_i,
  input wire logic [7:0] rd_data_i,
  output logic [4:0] index_o,
  output logic wr_pulse_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] host_data_lines_o,
  output logic host_data_lines_oe_o
);
  logic enable_ff;
  logic nxt_enable;
  logic [4:0] index_ff;
  logic [4:0] nxt_index;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic wr_ff;
  logic nxt_wr;
  logic fall;
  logic access;

  ////////////////////////////////////////////////////////////////////////
  // access only while selected; write lands on the falling enable edge
  always_comb begin
    access = !chip_sel_n_i;
    fall = enable_ff && !enable_i;
    nxt_enable = enable_i;
    nxt_index = index_ff;
    nxt_wdata = wdata_ff;
    nxt_wr = 1'b0;
    // data is sampled while enable is still high, so hold time is not needed
    if (access && enable_i && !rd_wr_n_i) begin
      nxt_wdata = host_data_lines_i;
    end
    if (access && fall && !rd_wr_n_i) begin
      if (!register_select_i) begin
        nxt_index = wdata_ff[4:0];
      end else begin
        nxt_wr = 1'b1;
      end
    end
  end

  // index register is kept across chip reset, like the control registers
  always_ff @(posedge core_clk_i) begin
    enable_ff <= nxt_enable;
    index_ff <= nxt_index;
    wdata_ff <= nxt_wdata;
    wr_ff <= nxt_wr;
  end

  ////////////////////////////////////////////////////////////////////////
  // drive only during a selected read with enable high
  always_comb begin
    host_data_lines_oe_o = access && rd_wr_n_i && enable_i && register_select_i;
    host_data_lines_o = host_data_lines_oe_o ? rd_data_i : 8'h00;
  end

  assign index_o = index_ff;
  assign wr_pulse_o = wr_ff;
  assign wr_data_o = wdata_ff;
endmodule
`default_nettype wire

// ---- hw/crtc_timing_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module crtc_timing_core #(
  parameter int ADDR_W = crtc_pkg::ADDR_W,
  parameter int ROW_W = crtc_pkg::ROW_W
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic char_clk_en_i,
  input wire logic chip_sel_n_i,
  input wire logic register_select_i,
  input wire logic rd_wr_n_i,
  input wire logic enable_i,
  input wire logic pen_hit_pulse_i,
  input wire logic [7:0] host_data_lines_i,
  output logic [7:0] host_data_lines_o,
  output logic host_data_lines_oe_o,
  output logic [ADDR_W-1:0] refresh_addr_o,
  output logic [ROW_W-1:0] row_in_char_line_o,
  output logic active_video_window_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic cursor_o
);
  logic [7:0] regs_ff [crtc_pkg::NUM_CTRL_REGS];
  logic [7:0] nxt_regs [crtc_pkg::NUM_CTRL_REGS];
  logic [4:0] index;
  logic wr_pulse;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic clear;
  logic [7:0] hcnt_ff, nxt_hcnt;
  logic [6:0] vcnt_ff, nxt_vcnt;
  logic [ROW_W-1:0] row_ff, nxt_row;
  logic [ROW_W-1:0] adj_ff, nxt_adj;
  logic in_adj_ff, nxt_in_adj;
  logic [3:0] hsw_ff, nxt_hsw;
  logic [3:0] vsw_ff, nxt_vsw;
  logic hs_ff, nxt_hs;
  logic vs_ff, nxt_vs;
  logic hde_ff, nxt_hde;
  logic vde_ff, nxt_vde;
  logic [ADDR_W-1:0] ma_ff, nxt_ma;
  logic [ADDR_W-1:0] row_base_ff, nxt_row_base;
  logic [ADDR_W-1:0] pen_ff, nxt_pen;
  logic pen_d_ff, nxt_pen_d;
  logic [4:0] blink_cnt_ff, nxt_blink_cnt;
  logic blink_ff, nxt_blink;
  logic [ADDR_W-1:0] start_addr, cur_addr;
  logic line_end, frame_end, row_last, vline_last;
  logic cur_row_ok, cur_vis;

  // two registers join into one 14-bit address
  function automatic logic [13:0] join14(input logic [7:0] hi, input logic [7:0] lo);
    join14 = {hi[5:0], lo};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // host side strobe logic
  crtc_host_bus crtc_host_bus_inst (
    .core_clk_i(core_clk_i),
    .chip_sel_n_i(chip_sel_n_i),
    .register_select_i(register_select_i),
    .rd_wr_n_i(rd_wr_n_i),
    .enable_i(enable_i),
    .host_data_lines_i(host_data_lines_i),
    .rd_data_i(rd_data),
    .index_o(index),
    .wr_pulse_o(wr_pulse),
    .wr_data_o(wr_data),
    .host_data_lines_o(host_data_lines_o),
    .host_data_lines_oe_o(host_data_lines_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // control registers; no reset term so programmed values survive a chip clear
  always_comb begin
    for (int i = 0; i < crtc_pkg::NUM_CTRL_REGS; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    // pen registers are read-only and index 16 up ignores writes
    if (wr_pulse && index < crtc_pkg::IDX_PEN_HI) begin
      nxt_regs[index] = wr_data;
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < crtc_pkg::NUM_CTRL_REGS; i++) begin
      regs_ff[i] <= nxt_regs[i];
    end
  end

  // only start, cursor and pen words are readable; the rest reads zero
  always_comb begin
    case (index)
      crtc_pkg::IDX_START_HI: rd_data = {2'h0, regs_ff[crtc_pkg::IDX_START_HI][5:0]};
      crtc_pkg::IDX_START_LO: rd_data = regs_ff[crtc_pkg::IDX_START_LO];
      crtc_pkg::IDX_CUR_HI: rd_data = {2'h0, regs_ff[crtc_pkg::IDX_CUR_HI][5:0]};
      crtc_pkg::IDX_CUR_LO: rd_data = regs_ff[crtc_pkg::IDX_CUR_LO];
      crtc_pkg::IDX_PEN_HI: rd_data = {2'h0, pen_ff[13:8]};
      crtc_pkg::IDX_PEN_LO: rd_data = pen_ff[7:0];
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded comparisons against programmed values
  always_comb begin
    clear = !rstn_i && !pen_hit_pulse_i;
    start_addr = join14(regs_ff[crtc_pkg::IDX_START_HI], regs_ff[crtc_pkg::IDX_START_LO]);
    cur_addr = join14(regs_ff[crtc_pkg::IDX_CUR_HI], regs_ff[crtc_pkg::IDX_CUR_LO]);
    line_end = (hcnt_ff == regs_ff[crtc_pkg::IDX_HTOTAL]);
    row_last = (row_ff == regs_ff[crtc_pkg::IDX_MAX_ROW][ROW_W-1:0]);
    vline_last = (vcnt_ff == regs_ff[crtc_pkg::IDX_VTOTAL][6:0]);
    frame_end = in_adj_ff ? (adj_ff == regs_ff[crtc_pkg::IDX_VADJ][ROW_W-1:0])
                          : (vline_last && row_last && regs_ff[crtc_pkg::IDX_VADJ][ROW_W-1:0] == 5'h00);
  end

  ////////////////////////////////////////////////////////////////////////
  // raster counters; advance once per character clock enable
  always_comb begin
    nxt_hcnt = hcnt_ff;
    nxt_vcnt = vcnt_ff;
    nxt_row = row_ff;
    nxt_adj = adj_ff;
    nxt_in_adj = in_adj_ff;
    nxt_hsw = hsw_ff;
    nxt_vsw = vsw_ff;
    nxt_hs = hs_ff;
    nxt_vs = vs_ff;
    nxt_hde = hde_ff;
    nxt_vde = vde_ff;
    nxt_ma = ma_ff;
    nxt_row_base = row_base_ff;
    if (clear) begin
      // counters cleared, timing halted while held
      nxt_hcnt = 8'h00;
      nxt_vcnt = 7'h00;
      nxt_row = '0;
      nxt_adj = '0;
      nxt_in_adj = 1'b0;
      nxt_hsw = 4'h0;
      nxt_vsw = 4'h0;
      nxt_hs = 1'b0;
      nxt_vs = 1'b0;
      nxt_hde = 1'b1;
      nxt_vde = 1'b1;
      nxt_ma = start_addr;
      nxt_row_base = start_addr;
    end else if (char_clk_en_i) begin
      nxt_hcnt = hcnt_ff + 8'h01;
      nxt_ma = ma_ff + 14'h0001;
      if (hcnt_ff + 8'h01 == regs_ff[crtc_pkg::IDX_HDISP]) begin
        nxt_hde = 1'b0;
      end
      // horizontal sync: start at position, run for the programmed width
      if (hs_ff) begin
        nxt_hsw = hsw_ff + 4'h1;
        if (hsw_ff + 4'h1 == regs_ff[crtc_pkg::IDX_SYNC_WIDTH][3:0]) begin
          nxt_hs = 1'b0;
        end
      end else if (hcnt_ff == regs_ff[crtc_pkg::IDX_HSYNC_POS]) begin
        nxt_hs = 1'b1;
        nxt_hsw = 4'h0;
      end
      if (line_end) begin
        nxt_hcnt = 8'h00;
        nxt_hde = 1'b1;
        nxt_ma = row_base_ff;
        // vertical sync counts in raster lines; width 0 means 16
        if (vs_ff) begin
          nxt_vsw = vsw_ff + 4'h1;
          if (vsw_ff + 4'h1 == regs_ff[crtc_pkg::IDX_SYNC_WIDTH][7:4]) begin
            nxt_vs = 1'b0;
          end
        end
        if (frame_end) begin
          nxt_vcnt = 7'h00;
          nxt_row = '0;
          nxt_adj = '0;
          nxt_in_adj = 1'b0;
          nxt_vde = 1'b1;
          nxt_ma = start_addr;
          nxt_row_base = start_addr;
        end else if (in_adj_ff) begin
          nxt_adj = adj_ff + 5'h01;
        end else if (row_last) begin
          nxt_row = '0;
          nxt_vcnt = vcnt_ff + 7'h01;
          nxt_row_base = row_base_ff + 14'(regs_ff[crtc_pkg::IDX_HDISP]);
          nxt_ma = row_base_ff + 14'(regs_ff[crtc_pkg::IDX_HDISP]);
          nxt_in_adj = vline_last;
          if (vcnt_ff + 7'h01 == regs_ff[crtc_pkg::IDX_VDISP][6:0]) begin
            nxt_vde = 1'b0;
          end
          if (vcnt_ff + 7'h01 == regs_ff[crtc_pkg::IDX_VSYNC_POS][6:0]) begin
            nxt_vs = 1'b1;
            nxt_vsw = 4'h0;
          end
        end else begin
          nxt_row = row_ff + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    hcnt_ff <= nxt_hcnt;
    vcnt_ff <= nxt_vcnt;
    row_ff <= nxt_row;
    adj_ff <= nxt_adj;
    in_adj_ff <= nxt_in_adj;
    hsw_ff <= nxt_hsw;
    vsw_ff <= nxt_vsw;
    hs_ff <= nxt_hs;
    vs_ff <= nxt_vs;
    hde_ff <= nxt_hde;
    vde_ff <= nxt_vde;
    ma_ff <= nxt_ma;
    row_base_ff <= nxt_row_base;
  end

  ////////////////////////////////////////////////////////////////////////
  // pen capture on rising strobe; blink counter per frame
  always_comb begin
    nxt_pen_d = pen_hit_pulse_i;
    nxt_pen = pen_ff;
    nxt_blink_cnt = blink_cnt_ff;
    nxt_blink = blink_ff;
    if (pen_hit_pulse_i && !pen_d_ff) begin
      nxt_pen = ma_ff;
    end
    if (clear) begin
      nxt_blink_cnt = 5'h00;
      nxt_blink = 1'b0;
    end else if (char_clk_en_i && line_end && frame_end) begin
      nxt_blink_cnt = blink_cnt_ff + 5'h01;
      if (blink_cnt_ff == (regs_ff[crtc_pkg::IDX_CUR_START][6]
                           ? crtc_pkg::BLINK_SLOW_FIELDS : crtc_pkg::BLINK_FAST_FIELDS)) begin
        nxt_blink_cnt = 5'h00;
        nxt_blink = !blink_ff;
      end
    end
  end

  // pen register has no reset term: it is a readable register, kept across clear
  always_ff @(posedge core_clk_i) begin
    pen_d_ff <= nxt_pen_d;
    pen_ff <= nxt_pen;
    blink_cnt_ff <= nxt_blink_cnt;
    blink_ff <= nxt_blink;
  end

  ////////////////////////////////////////////////////////////////////////
  // cursor: address match, row window and blink mode
  always_comb begin
    cur_row_ok = (row_ff >= regs_ff[crtc_pkg::IDX_CUR_START][ROW_W-1:0]) &&
                 (row_ff <= regs_ff[crtc_pkg::IDX_CUR_END][ROW_W-1:0]);
    case (regs_ff[crtc_pkg::IDX_CUR_START][6:5])
      crtc_pkg::CUR_ON: cur_vis = 1'b1;
      crtc_pkg::CUR_OFF: cur_vis = 1'b0;
      crtc_pkg::CUR_FAST: cur_vis = blink_ff;
      crtc_pkg::CUR_SLOW: cur_vis = blink_ff;
      default: cur_vis = 1'b0;
    endcase
  end

  // outputs are flops gated by clear, cursor is decoded from them; all forced low during a clear
  always_comb begin
    refresh_addr_o = clear ? '0 : ma_ff;
    row_in_char_line_o = clear ? '0 : row_ff;
    active_video_window_o = !clear && hde_ff && vde_ff && !in_adj_ff;
    hsync_o = !clear && hs_ff;
    vsync_o = !clear && vs_ff;
    cursor_o = active_video_window_o && cur_vis && cur_row_ok && (ma_ff == cur_addr);
  end
endmodule
`default_nettype wire

// ---- dv/crtc_timing_core_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module crtc_timing_core_chk #(
  parameter int ADDR_W = 14,
  parameter int ROW_W = 5
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic char_clk_en_i,
  input wire logic chip_sel_n_i,
  input wire logic register_select_i,
  input wire logic rd_wr_n_i,
  input wire logic enable_i,
  input wire logic pen_hit_pulse_i,
  input wire logic [7:0] host_data_lines_i,
  input wire logic [7:0] host_data_lines_o,
  input wire logic host_data_lines_oe_o,
  input wire logic [ADDR_W-1:0] refresh_addr_o,
  input wire logic [ROW_W-1:0] row_in_char_line_o,
  input wire logic active_video_window_o,
  input wire logic hsync_o,
  input wire logic vsync_o,
  input wire logic cursor_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////
  // full read cycle as seen on the host pins
  logic host_read;
  assign host_read = !chip_sel_n_i && register_select_i && rd_wr_n_i && enable_i;
  ////////////////////////////////////////////////////////////////////////////
  // bus side
  AST_OE_ONLY_READ: assert property (host_data_lines_oe_o |-> !chip_sel_n_i && rd_wr_n_i && enable_i)
    else $error("data lines driven outside a host read");
  AST_READ_DRIVES: assert property (host_read |-> host_data_lines_oe_o)
    else $error("host read not answered");
  AST_DESELECT_QUIET: assert property (chip_sel_n_i |-> !host_data_lines_oe_o && host_data_lines_o == 8'h00)
    else $error("deselected device drives data");
  AST_INDEX_NOT_READ: assert property ((!chip_sel_n_i && !register_select_i)[*2] |-> !host_data_lines_oe_o)
    else $error("index register read back");
  ////////////////////////////////////////////////////////////////////////////
  // clear and timing side; the clear check cannot be masked by the clear itself
  AST_CLEAR_LOW: assert property (disable iff (1'b0) (!rstn_i && !pen_hit_pulse_i) |->
    refresh_addr_o == '0 && row_in_char_line_o == '0 && !active_video_window_o && !hsync_o && !vsync_o && !cursor_o)
    else $error("output not low during clear");
  AST_CLEARED_ROW: assert property ($rose(rstn_i) && !$past(pen_hit_pulse_i) |-> row_in_char_line_o == '0)
    else $error("row counter not cleared");
  AST_CHAR_STEP: assert property ($past(rstn_i) && !$past(char_clk_en_i) |->
    $stable(refresh_addr_o) && $stable(row_in_char_line_o))
    else $error("timing moved without a character tick");
  AST_CURSOR_IN_WINDOW: assert property (cursor_o |-> active_video_window_o)
    else $error("cursor outside display window");
  COV_READ: cover property (host_read);
  COV_PEN: cover property ($rose(pen_hit_pulse_i));
  COV_CURSOR: cover property (cursor_o);
  COV_CLEAR_BLOCKED: cover property (disable iff (1'b0) !rstn_i && pen_hit_pulse_i);
endmodule
bind crtc_timing_core crtc_timing_core_chk #(.ADDR_W(ADDR_W), .ROW_W(ROW_W)) chk_inst (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .char_clk_en_i(char_clk_en_i), .chip_sel_n_i(chip_sel_n_i),
  .register_select_i(register_select_i), .rd_wr_n_i(rd_wr_n_i), .enable_i(enable_i),
  .pen_hit_pulse_i(pen_hit_pulse_i), .host_data_lines_i(host_data_lines_i), .host_data_lines_o(host_data_lines_o),
  .host_data_lines_oe_o(host_data_lines_oe_o), .refresh_addr_o(refresh_addr_o),
  .row_in_char_line_o(row_in_char_line_o), .active_video_window_o(active_video_window_o),
  .hsync_o(hsync_o), .vsync_o(vsync_o), .cursor_o(cursor_o));
`default_nettype wire

// ---- dv/crtc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module crtc_host_model #(
  parameter logic [15:0] HOST_BASE = 16'h4000
) (
  input wire logic core_clk_i,
  input wire logic [7:0] rdata_i,
  output logic chip_sel_n_o,
  output logic register_select_o,
  output logic rd_wr_n_o,
  output logic enable_o,
  output logic [7:0] wdata_o
);
  // idle bus: deselected, strobe low
  initial begin
    chip_sel_n_o = 1'b1;
    register_select_o = 1'b0;
    rd_wr_n_o = 1'b1;
    enable_o = 1'b0;
    wdata_o = 8'ha5;
  end
  // one strobe cycle; released data lines flip so stale values never look valid
  task automatic access(input logic a0, input logic valid_mem_access, input logic rw, input logic [7:0] wd,
                        output logic [7:0] rd);
    logic [15:0] addr;
    addr = HOST_BASE | {15'h0000, a0};
    @(negedge core_clk_i);
    chip_sel_n_o = ~(valid_mem_access && addr[15:1] == HOST_BASE[15:1]);
    register_select_o = addr[0];
    rd_wr_n_o = rw;
    wdata_o = rw ? ~wdata_o : wd;
    enable_o = 1'b1;
    repeat (2) @(posedge core_clk_i);
    rd = rdata_i;
    @(negedge core_clk_i);
    enable_o = 1'b0;
    @(negedge core_clk_i);
    chip_sel_n_o = 1'b1;
    wdata_o = ~wdata_o;
  endtask
endmodule
`default_nettype wire

// ---- dv/crtc_host_port_and_reset_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module crtc_host_port_and_reset_bench;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic char_clk_en_i = 1'b0;
  logic pen_hit_pulse_i = 1'b0;
  logic chip_sel_n, register_select, rd_wr_n, enable, rdata_oe, hsync, vsync, active, cursor;
  logic [7:0] wdata, rdata;
  logic [13:0] raddr;
  logic [4:0] row;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  // small raster: cursor sits one character after the start address
  logic [7:0] prog [18] = '{8'h0b, 8'h06, 8'h08, 8'h22, 8'h04, 8'h00, 8'h03, 8'h03, 8'h00,
                            8'h01, 8'h00, 8'h01, 8'h01, 8'h20, 8'hc1, 8'h21, 8'hff, 8'hff};
  ////////////////////////////////////////////////////////////////////////////
  crtc_host_model crtc_host_model_inst (.core_clk_i(core_clk_i), .rdata_i(rdata), .chip_sel_n_o(chip_sel_n),
    .register_select_o(register_select), .rd_wr_n_o(rd_wr_n), .enable_o(enable), .wdata_o(wdata));
  crtc_timing_core crtc_timing_core_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .char_clk_en_i(char_clk_en_i),
    .chip_sel_n_i(chip_sel_n), .register_select_i(register_select), .rd_wr_n_i(rd_wr_n), .enable_i(enable),
    .pen_hit_pulse_i(pen_hit_pulse_i), .host_data_lines_i(wdata), .host_data_lines_o(rdata),
    .host_data_lines_oe_o(rdata_oe), .refresh_addr_o(raddr), .row_in_char_line_o(row),
    .active_video_window_o(active), .hsync_o(hsync), .vsync_o(vsync), .cursor_o(cursor));
  ////////////////////////////////////////////////////////////////////////////
  // clock, character tick every other cycle, hang guard
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) char_clk_en_i <= ~char_clk_en_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] x;
    crtc_host_model_inst.access(1'b0, 1'b1, 1'b0, {3'h0, idx}, x);
    crtc_host_model_inst.access(1'b1, 1'b1, 1'b0, d, x);
  endtask
  task automatic rd(input logic [4:0] idx, output logic [7:0] d);
    logic [7:0] x;
    crtc_host_model_inst.access(1'b0, 1'b1, 1'b0, {3'h0, idx}, x);
    crtc_host_model_inst.access(1'b1, 1'b1, 1'b1, 8'h00, d);
  endtask
  // program all, read back the start and cursor pairs and one write-only place
  task automatic t_regs;
    logic [7:0] d;
    // program while the raster is held again; the first release lets it run one cycle on unknown registers
    @(negedge core_clk_i);
    rstn_i = 1'b0;
    for (int i = 0; i < 18; i++) wr(i[4:0], prog[i]);
    rstn_i = 1'b1;
    for (int i = 12; i < 16; i++) begin
      rd(i[4:0], d);
      `CHK("ctrl_rd", prog[i] & (i[0] ? 8'hff : 8'h3f), d)
    end
    rd(crtc_pkg::IDX_HTOTAL, d);
    `CHK("wo_rd", 8'h00, d)
  endtask
  // a write without a valid access must not land
  task automatic t_cs;
    logic [7:0] d;
    crtc_host_model_inst.access(1'b0, 1'b1, 1'b0, {3'h0, crtc_pkg::IDX_START_LO}, d);
    crtc_host_model_inst.access(1'b1, 1'b0, 1'b0, 8'h55, d);
    rd(crtc_pkg::IDX_START_LO, d);
    `CHK("cs_high_wr", prog[13], d)
  endtask
  // clear in mid-frame, then the frame restarts from the start address
  task automatic t_clear;
    logic [7:0] d;
    @(negedge core_clk_i);
    rstn_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    `CHK("clear_out", 23'h0, {raddr, row, active, hsync, vsync, cursor})
    rstn_i = 1'b1;
    // two character ticks in four cycles: counting restarts from the start address at once
    repeat (4) @(negedge core_clk_i);
    `CHK("resume_addr", 14'h0122, raddr)
    rd(crtc_pkg::IDX_START_LO, d);
    `CHK("kept_reg", prog[13], d)
    wait (vsync === 1'b1);
    wait (vsync === 1'b0);
    wait (active === 1'b1);
    @(negedge core_clk_i);
    `CHK("frame_addr", 14'h0120, raddr)
  endtask
  // clear is ignored while the pen strobe is high; the strobe edge captures the address
  task automatic t_pen;
    logic [7:0] hi, lo;
    logic [13:0] exp;
    int seen;
    @(negedge core_clk_i);
    exp = raddr;
    pen_hit_pulse_i = 1'b1;
    rstn_i = 1'b0;
    seen = 0;
    repeat (300) begin
      @(negedge core_clk_i);
      if (hsync === 1'b1) seen++;
    end
    `CHK("clear_blocked", 1'b1, seen > 0)
    rstn_i = 1'b1;
    pen_hit_pulse_i = 1'b0;
    rd(crtc_pkg::IDX_PEN_HI, hi);
    rd(crtc_pkg::IDX_PEN_LO, lo);
    `CHK("pen_pos", {2'b00, exp}, {hi, lo})
  endtask
  // cursor shows at its programmed address
  task automatic t_cursor;
    wait (cursor === 1'b0);
    wait (cursor === 1'b1);
    @(negedge core_clk_i);
    `CHK("cursor_addr", 14'h0121, raddr)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge core_clk_i);
    rstn_i = 1'b1;
    t_regs;
    t_cs;
    t_clear;
    t_pen;
    t_cursor;
    finish_test;
  end
endmodule
`default_nettype wire
